//--- src/iwb_pkg.sv
/*
  constants for the i2c slave register write bridge: register offsets,
  slave pointer offsets, reset values and field positions.
  assumes a little-endian bit numbering view where bit 00 is the lsb.
*/
package iwb_pkg;
  // ************************************************************
  // register bus offsets
  // ************************************************************
  localparam logic [23:0] WRITE_TARGET_ADDRESS_OFFSET   = 24'h01d200;
  localparam logic [23:0] WDATA_OFFSET   = 24'h01d204;
  // ************************************************************
  // slave peripheral pointer offsets
  // ************************************************************
  localparam logic [7:0]  PTR_ADDR_FIRST = 8'h00;
  localparam logic [7:0]  PTR_ADDR_LAST  = 8'h03;
  localparam logic [7:0]  PTR_DATA_FIRST = 8'h04;
  localparam logic [7:0]  PTR_DATA_LAST  = 8'h07;
  // ************************************************************
  // reset values and fields
  // ************************************************************
  localparam logic [31:0] WRITE_TARGET_ADDRESS_RESET    = 32'h00000000;
  localparam logic [31:0] WDATA_RESET    = 32'h00000000;
  localparam logic [31:0] ADDR_ALIGN_MSK = 32'hfffffffc;
  localparam logic [31:0] ADDR_STEP      = 32'h00000004;
  localparam int          ADDR_USED_BITS = 24;
endpackage : iwb_pkg

//--- src/iwb_write_bridge.sv
/*
  write side of the i2c slave to internal register bus bridge.
  assumes an i2c bit-level slave that presents one byte access per cycle
  with the current pointer, a boot loader that supplies address and data
  words, and an internal bus that takes a one-cycle write strobe.
*/
// Function
// - write address bits 1:0 are always zero, whoever writes
// - both registers read only from internal bus, r/w from i2c
// - address register bytes sit at pointer offsets 0x00 to 0x03
// - data register bytes at 0x04 to 0x07, 0x07 holds the msb
// - only low 24 address bits drive the internal access
// - four-byte size: writing offset 0x07 issues the internal write
// - internal write target comes from the write address register
// - writes to offsets 0x04 to 0x06 only store the byte
// - with auto increment and four-byte size, address grows by 4 on each 0x07 write
// - after writing 0x07 the pointer returns to 0x04
// - after reading 0x07 the pointer advances to 0x08
// - pointer offset in data register selects the byte accessed
// - boot load collects each eeprom address into address register
// - boot load collects each eeprom data word into data register
// - both registers reset to zero; data keeps last written value
`timescale 1ns/10ps
module iwb_write_bridge #(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // i2c slave byte access
  input  wire logic        slv_wr,
  input  wire logic        slv_rd,
  input  wire logic [7:0]  slv_wdata,
  input  wire logic        slv_ptr_load,
  input  wire logic [7:0]  slv_ptr_value,
  output logic      [7:0]  slv_ptr,
  output logic      [7:0]  slv_rdata,
  // access control settings
  input  wire logic        write_auto_increment,
  input  wire logic        write_access_size,
  // boot loader capture
  input  wire logic        boot_addr_load,
  input  wire logic        boot_data_load,
  input  wire logic [31:0] boot_word,
  // internal register bus read
  input  wire logic        reg_rd,
  input  wire logic [23:0] reg_addr,
  output logic      [31:0] reg_rdata,
  // internal register bus write master
  output logic             int_wr,
  output logic      [ADDR_W-1:0] int_addr,
  output logic      [31:0] int_wdata
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ADDR_W != iwb_pkg::ADDR_USED_BITS) begin : g_chk
    $error("ADDR_W must equal the used address width");
  end

  // byte lane of a 32-bit word, lane 0 is the most significant byte
  function automatic logic [7:0] lane_get(input logic [31:0] w,
                                          input logic [1:0]  ln);
    lane_get = w[8*(3-ln) +: 8];
  endfunction : lane_get

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0]       write_target_address_reg, write_target_address_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [7:0]        ptr_reg, ptr_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic [31:0]       regrd_reg, regrd_next;
  logic              wr_reg, wr_next;
  logic [ADDR_W-1:0] iaddr_reg, iaddr_next;
  logic [31:0]       iwdata_reg, iwdata_next;
  logic              in_addr, in_data, last_data;
  logic [1:0]        lane;
  logic [31:0]       merged;

  // ************************************************************
  // next-value logic
  // ************************************************************
  always_comb begin
    in_addr     = (ptr_reg >= iwb_pkg::PTR_ADDR_FIRST) &&
                  (ptr_reg <= iwb_pkg::PTR_ADDR_LAST);
    in_data     = (ptr_reg >= iwb_pkg::PTR_DATA_FIRST) &&
                  (ptr_reg <= iwb_pkg::PTR_DATA_LAST);
    last_data   = (ptr_reg == iwb_pkg::PTR_DATA_LAST);
    lane        = ptr_reg[1:0];
    write_target_address_next  = write_target_address_reg;
    wdata_next  = wdata_reg;
    ptr_next    = ptr_reg;
    rdata_next  = rdata_reg;
    regrd_next  = regrd_reg;
    wr_next     = 1'b0;
    iaddr_next  = iaddr_reg;
    iwdata_next = iwdata_reg;
    merged      = wdata_reg;
    // byte writes from the i2c master
    if (slv_wr) begin
      if (in_addr) begin
        write_target_address_next[8*(3-lane) +: 8] = slv_wdata;
      end
      // data bytes ascend in weight: 0x04 is the lsb, 0x07 the msb
      if (in_data) begin
        merged[8*lane +: 8] = slv_wdata;
        wdata_next = merged;
      end
      if (last_data) begin
        ptr_next = iwb_pkg::PTR_DATA_FIRST;
        if (write_access_size) begin
          wr_next     = 1'b1;
          iaddr_next  = write_target_address_reg[ADDR_W-1:0];
          iwdata_next = merged;
          if (write_auto_increment) begin
            write_target_address_next = write_target_address_reg + iwb_pkg::ADDR_STEP;
          end
        end
      end else begin
        ptr_next = ptr_reg + 8'h01;
      end
    end else if (slv_rd) begin
      // reads return the byte and advance the pointer, unless a pointer load comes in the same cycle
      if (in_addr) begin
        rdata_next = lane_get(write_target_address_reg, lane);
      end else if (in_data) begin
        rdata_next = wdata_reg[8*lane +: 8];
      end else begin
        rdata_next = 8'h00;
      end
      ptr_next = ptr_reg + 8'h01;
    end
    if (slv_ptr_load) begin
      ptr_next = slv_ptr_value;
    end
    // boot loader capture wins over a concurrent i2c byte
    if (boot_addr_load) begin
      write_target_address_next = boot_word;
    end
    if (boot_data_load) begin
      wdata_next = boot_word;
    end
    write_target_address_next = write_target_address_next & iwb_pkg::ADDR_ALIGN_MSK;
    // internal bus reads only, no write path exists
    if (reg_rd) begin
      if (reg_addr == iwb_pkg::WRITE_TARGET_ADDRESS_OFFSET) begin
        regrd_next = write_target_address_reg;
      end else if (reg_addr == iwb_pkg::WDATA_OFFSET) begin
        regrd_next = wdata_reg;
      end else begin
        regrd_next = 32'h00000000;
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_target_address_reg  <= iwb_pkg::WRITE_TARGET_ADDRESS_RESET;
      wdata_reg  <= iwb_pkg::WDATA_RESET;
      ptr_reg    <= iwb_pkg::PTR_ADDR_FIRST;
      rdata_reg  <= 8'h00;
      regrd_reg  <= 32'h00000000;
      wr_reg     <= 1'b0;
      iaddr_reg  <= '0;
      iwdata_reg <= 32'h00000000;
    end else begin
      write_target_address_reg  <= write_target_address_next;
      wdata_reg  <= wdata_next;
      ptr_reg    <= ptr_next;
      rdata_reg  <= rdata_next;
      regrd_reg  <= regrd_next;
      wr_reg     <= wr_next;
      iaddr_reg  <= iaddr_next;
      iwdata_reg <= iwdata_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign slv_ptr   = ptr_reg;
  assign slv_rdata = rdata_reg;
  assign reg_rdata = regrd_reg;
  assign int_wr    = wr_reg;
  assign int_addr  = iaddr_reg;
  assign int_wdata = iwdata_reg;

endmodule : iwb_write_bridge

//--- verification/iwb_i2c_master.sv
/* partner: the i2c master side, one byte request per call of put.
   assumes the bench shares clk and calls put from its main sequence. */
`timescale 1ns/10ps
module iwb_i2c_master (
  // clock
  input  wire logic clk,
  // byte requests
  output logic       slv_wr,
  output logic       slv_rd,
  output logic       slv_ptr_load,
  output logic [7:0] slv_wdata,
  output logic [7:0] slv_ptr_value
);
  // idle lines from time zero
  initial {slv_wr, slv_rd, slv_ptr_load, slv_wdata, slv_ptr_value} = 19'h0;
  // op 0 write, 1 pointer load, 2 read; released bytes show the inverse
  task automatic put(input logic [1:0] op, input logic [7:0] b);
    @(posedge clk);
    slv_wr <= op == 2'h0;
    slv_ptr_load <= op == 2'h1;
    slv_rd <= op == 2'h2;
    {slv_wdata, slv_ptr_value} <= {b, b};
    @(posedge clk);
    {slv_wr, slv_ptr_load, slv_rd} <= 3'h0;
    {slv_wdata, slv_ptr_value} <= ~{b, b};
  endtask : put
endmodule : iwb_i2c_master

//--- verification/iwb_chk.sv
/* checker on the bridge ports.
   assumes a bind onto iwb_write_bridge that hands ADDR_W on. */
`timescale 1ns/10ps
module iwb_chk #(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // i2c side
  input wire logic              slv_wr,
  input wire logic              slv_rd,
  input wire logic              slv_ptr_load,
  input wire logic [7:0]        slv_wdata,
  input wire logic [7:0]        slv_ptr,
  input wire logic              write_access_size,
  // register bus side
  input wire logic              reg_rd,
  input wire logic [23:0]       reg_addr,
  input wire logic [31:0]       reg_rdata,
  input wire logic              int_wr,
  input wire logic [ADDR_W-1:0] int_addr,
  input wire logic [31:0]       int_wdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // byte write at the data msb offset
  sequence s_msb;
    slv_wr && !slv_ptr_load && slv_ptr == 8'h07;
  endsequence
  wr_fire_a: assert property (s_msb ##0 write_access_size |=> int_wr
    && int_wdata[31:24] == $past(slv_wdata)) else $error("no write");
  wr_cause_a: assert property (int_wr |-> $past(slv_wr) &&
    $past(slv_ptr) == 8'h07 && $past(write_access_size)) else $error("stray");
  ptr_wrap_a: assert property (s_msb |=> slv_ptr == 8'h04)
    else $error("no wrap");
  ptr_adv_a: assert property (slv_rd && !slv_wr && !slv_ptr_load &&
    slv_ptr == 8'h07 |=> slv_ptr == 8'h08) else $error("no advance");
  addr_align_a: assert property (int_wr |-> int_addr[1:0] == 2'h0)
    else $error("unaligned");
  target_hold_a: assert property (!int_wr |-> $stable(int_addr)
    && $stable(int_wdata)) else $error("target moved");
  unmapped_a: assert property (reg_rd && reg_addr != 24'h01d200 &&
    reg_addr != 24'h01d204 |=> reg_rdata == 32'h0) else $error("unmapped");
  reg_align_a: assert property (reg_rd && reg_addr == 24'h01d200
    |=> reg_rdata[1:0] == 2'h0) else $error("addr bits");
endmodule : iwb_chk

//--- verification/tb_top.sv
/* self-checking bench: partner master, scoreboard queues, bound checker.
   assumes the package, bridge, partner and checker are compiled first. */
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst_n = 0, inc = 0, size = 1, bal = 0, bdl = 0, rd = 0;
  logic rd_d = 0, sr_d = 0, slv_wr, slv_rd, slv_ld, int_wr;
  logic [7:0] slv_wdata, slv_pv, slv_ptr, slv_rdata;
  logic [23:0] ra = 24'h0, int_addr;
  logic [31:0] bw = 32'h0, rdata, int_wdata, wa, wd;
  logic [55:0] wq[$], rq[$], bq[$];
  int miscompares = 0, n_checks = 0, cyc = 0, seed = 44, i, j;
  always #2.5 clk = ~clk;
  iwb_i2c_master u_mst (.clk, .slv_wr, .slv_rd, .slv_ptr_load(slv_ld),
    .slv_wdata, .slv_ptr_value(slv_pv));
  iwb_write_bridge #(.ADDR_W(24)) u_dut (.clk, .rst_n, .slv_wr, .slv_rd,
    .slv_wdata, .slv_ptr_load(slv_ld), .slv_ptr_value(slv_pv), .slv_ptr,
    .slv_rdata, .write_auto_increment(inc), .write_access_size(size),
    .boot_addr_load(bal), .boot_data_load(bdl), .boot_word(bw),
    .reg_rd(rd), .reg_addr(ra), .reg_rdata(rdata), .int_wr, .int_addr,
    .int_wdata);
  // compare one note with one result
  task automatic chk(input string nm, input logic [55:0] e, g);
    n_checks++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // register bus read, expected word noted first
  task automatic rreg(input logic [23:0] a, input logic [31:0] e);
    rq.push_back({24'h0, e});
    @(posedge clk);
    {rd, ra} <= {1'b1, a};
    @(posedge clk);
    {rd, ra} <= {1'b0, ~a};
  endtask : rreg
  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // monitor: oldest note against each result, then the hang limit
  always @(posedge clk) begin
    rd_d <= rd;
    sr_d <= slv_rd;
    if (sr_d) chk("slv_rdata", bq.pop_front(), {48'h0, slv_rdata});
    cyc <= cyc + 1;
    if (int_wr) chk("int_wr", wq.pop_front(), {int_addr, int_wdata});
    if (rd_d) chk("reg_rdata", rq.pop_front(), {24'h0, rdata});
    if (cyc > 2000) begin
      miscompares++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rreg(24'h01d200, 32'h0);
    rreg(24'h01d204, 32'h0);
    rreg(24'h01d208, 32'h0);
    wa = $random(seed);
    u_mst.put(1, 8'h00);
    for (i = 0; i < 4; i++) u_mst.put(0, wa[31-8*i -: 8]);
    wa = wa & iwb_pkg::ADDR_ALIGN_MSK;
    rreg(24'h01d200, wa);
    inc <= 1;
    u_mst.put(1, 8'h04);
    for (j = 0; j < 3; j++) begin
      wd = $random(seed);
      size <= j != 1;
      if (j != 1) wq.push_back({wa[23:0], wd});
      for (i = 0; i < 4; i++) u_mst.put(0, wd[8*i +: 8]);
      if (j != 1) wa = wa + 32'h4;
    end
    rreg(24'h01d204, wd);
    rreg(24'h01d200, wa);
    u_mst.put(1, 8'h07);
    bq.push_back({48'h0, wd[31:24]});
    u_mst.put(2, 8'h00);
    for (i = 0; i < 2; i++) begin
      wd = $random(seed);
      @(posedge clk);
      {bw, bal, bdl} <= {wd, i == 0, i == 1};
      @(posedge clk);
      {bal, bdl} <= 2'h0;
      if (i == 0) rreg(24'h01d200, wd & 32'hfffffffc);
      else rreg(24'h01d204, wd);
    end
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : tb_top
bind iwb_write_bridge iwb_chk #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst_n,
  .slv_wr, .slv_rd, .slv_ptr_load, .slv_wdata, .slv_ptr, .write_access_size,
  .reg_rd, .reg_addr, .reg_rdata, .int_wr, .int_addr, .int_wdata);
